// [hdl/chan_loader_pkg.sv]
// Purpose: Shared constants for the addressed channel loader
// Assumes: One 100 MHz clock; panel pins are synchronous to it
// Notes:   Register offsets are byte addresses on the plain register port
package chan_loader_pkg;
    localparam int NUM_CH    = 6;
    localparam int WORD_W    = 10;
    localparam int SEL_W     = 3;
    localparam int LOG_W     = SEL_W + WORD_W;
    localparam int LOG_DEPTH = 32;
    localparam int LVL_W     = 6;
    localparam int ADDR_W    = 4;
    localparam int DATA_W    = 32;

    localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] LOG_OFS    = 4'h8;

    localparam int CTRL_LOG_EN_BIT  = 0;
    localparam int STAT_LOW_POWER_SELECT_BIT    = 8;
    localparam int STAT_DROP_BIT    = 9;
    localparam int LOG_VALID_BIT    = 16;
    localparam logic CTRL_LOG_EN_RST = 1'b0;
endpackage : chan_loader_pkg

// [hdl/chan_loader.sv]
// Purpose: Addressed channel loading, simultaneous transfer and standby clear
// Assumes: Panel clock and control pins arrive synchronous to clk_i
// Notes:   A 32-word log records each loaded word while logging is enabled and the log is not full, for software readback
`timescale 1ns/1ns
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 32
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [WIDTH-1:0]                out_data_o,
    output logic [$clog2(DEPTH+1)-1:0]      level_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic             ready_reg;
    wire              push_w = in_valid_i & ready_reg;
    wire              pop_w  = out_valid_o & out_ready_i;

    assign count_next  = count_reg + CW'(push_w) - CW'(pop_w);
    assign in_ready_o  = ready_reg;
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem[rd_ptr_reg];
    assign level_o     = count_reg;

    always_ff @(posedge clk_i) begin
        if (push_w) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b0;
        end else begin
            wr_ptr_reg <= push_w ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            rd_ptr_reg <= pop_w ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
            count_reg  <= count_next;
            ready_reg  <= (count_next < CW'(DEPTH));
        end
    end
endmodule // word_fifo

module chan_loader (
    input  wire logic                                             clk_i,
    input  wire logic                                             reset_n_i,
    input  wire logic                                             panel_clk_i,
    input  wire logic [chan_loader_pkg::SEL_W-1:0]                chan_sel_i,
    input  wire logic [chan_loader_pkg::WORD_W-1:0]               video_word_i,
    input  wire logic                                             sequence_start_in_i,
    input  wire logic                                             output_transfer_in_i,
    input  wire logic                                             low_power_select_i,
    input  wire logic [chan_loader_pkg::ADDR_W-1:0]               reg_addr_i,
    input  wire logic [chan_loader_pkg::DATA_W-1:0]               reg_wdata_i,
    input  wire logic                                             reg_wr_i,
    input  wire logic                                             reg_rd_i,
    output logic [chan_loader_pkg::DATA_W-1:0]                    reg_rdata_o,
    output logic [chan_loader_pkg::NUM_CH*chan_loader_pkg::WORD_W-1:0] chan_words_o,
    output logic [chan_loader_pkg::NUM_CH-1:0]                    chan_valid_o,
    output logic                                                  standby_o,
    output logic                                                  log_ready_o
);
    import chan_loader_pkg::*;

    logic                             rst_meta_reg;
    logic                             rst_n_reg;
    logic                             pclk_reg;
    logic [SEL_W-1:0]                 sel_reg;
    logic                             xfr_pend_reg;
    logic                             log_en_reg;
    logic                             log_drop_reg;
    logic [DATA_W-1:0]                rdata_reg;
    logic [NUM_CH-1:0][WORD_W-1:0]    stage1_reg;
    logic [NUM_CH-1:0][WORD_W-1:0]    stage1_next;
    logic [NUM_CH-1:0][WORD_W-1:0]    stage2_reg;
    logic [NUM_CH-1:0]                valid1_reg;
    logic [NUM_CH-1:0]                valid1_next;
    logic [NUM_CH-1:0]                valid2_reg;
    logic                             log_in_ready;
    logic                             log_out_valid;
    logic [LOG_W-1:0]                 log_out_data;
    logic [LVL_W-1:0]                 log_level;
    logic                             pclk_low_power_select_reg;

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Panel clock edges and load qualification
    wire low_power_select_w      = low_power_select_i;
    wire rise_w      = panel_clk_i & ~pclk_reg;
    wire fall_w      = ~panel_clk_i & pclk_reg;
    wire sel_ok_w    = (sel_reg < SEL_W'(NUM_CH));
    wire load_w      = fall_w & sequence_start_in_i & ~low_power_select_w;
    wire load_hit_w  = load_w & sel_ok_w;
    wire xfer_w      = fall_w & xfr_pend_reg & ~low_power_select_w;
    wire log_push_w  = load_hit_w & log_en_reg;
    wire wr_ctrl_w   = reg_wr_i & (reg_addr_i == CTRL_OFS);
    wire wr_stat_w   = reg_wr_i & (reg_addr_i == STATUS_OFS);
    wire pop_log_w   = reg_rd_i & (reg_addr_i == LOG_OFS);
    wire drop_set_w  = log_push_w & ~log_in_ready;

    wire [DATA_W-1:0] ctrl_rd_w = DATA_W'(log_en_reg);
    wire [DATA_W-1:0] stat_rd_w = DATA_W'({log_drop_reg, low_power_select_w, 2'h0, log_level});
    wire [DATA_W-1:0] log_rd_w  = DATA_W'({log_out_valid, 3'h0, log_out_data});
    wire [DATA_W-1:0] rd_mux_w  = (reg_addr_i == CTRL_OFS)   ? ctrl_rd_w :
                                  (reg_addr_i == STATUS_OFS) ? stat_rd_w :
                                  (reg_addr_i == LOG_OFS)    ? log_rd_w  : 32'h0000_0000;

    genvar k;
    generate
        for (k = 0; k < NUM_CH; k++) begin : g_chan
            wire hit_w = load_hit_w & (sel_reg == SEL_W'(k));
            assign stage1_next[k] = hit_w ? video_word_i : stage1_reg[k];
            assign valid1_next[k] = hit_w | valid1_reg[k];

            // First stage takes the word; second stage only on transfer
            always_ff @(posedge clk_i or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    stage1_reg[k] <= '0;
                    valid1_reg[k] <= 1'b0;
                    stage2_reg[k] <= '0;
                    valid2_reg[k] <= 1'b0;
                end else if (low_power_select_w) begin
                    stage1_reg[k] <= '0;
                    valid1_reg[k] <= 1'b0;
                    stage2_reg[k] <= '0;
                    valid2_reg[k] <= 1'b0;
                end else begin
                    stage1_reg[k] <= stage1_next[k];
                    valid1_reg[k] <= valid1_next[k];
                    if (xfer_w) begin
                        stage2_reg[k] <= stage1_next[k];
                        valid2_reg[k] <= valid1_next[k];
                    end
                end
            end
            assign chan_words_o[k*WORD_W +: WORD_W] = stage2_reg[k];
        end
    endgenerate

    assign chan_valid_o = valid2_reg;
    assign reg_rdata_o  = rdata_reg;
    assign standby_o    = pclk_low_power_select_reg;

    // Address on rising edge, transfer qualified until next falling edge
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pclk_reg      <= 1'b0;
            sel_reg       <= '0;
            xfr_pend_reg  <= 1'b0;
            pclk_low_power_select_reg <= 1'b0;
        end else begin
            pclk_reg      <= panel_clk_i;
            pclk_low_power_select_reg <= low_power_select_w;
            if (low_power_select_w) begin
                xfr_pend_reg <= 1'b0;
            end else if (rise_w) begin
                sel_reg      <= chan_sel_i;
                xfr_pend_reg <= output_transfer_in_i;
            end else if (fall_w) begin
                xfr_pend_reg <= 1'b0;
            end
        end
    end

    // Register port
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            log_en_reg   <= CTRL_LOG_EN_RST;
            log_drop_reg <= 1'b0;
            rdata_reg    <= '0;
        end else begin
            if (wr_ctrl_w) begin
                log_en_reg <= reg_wdata_i[CTRL_LOG_EN_BIT];
            end
            if (drop_set_w) begin
                log_drop_reg <= 1'b1;
            end else if (wr_stat_w && reg_wdata_i[STAT_DROP_BIT]) begin
                log_drop_reg <= 1'b0;
            end
            rdata_reg <= reg_rd_i ? rd_mux_w : '0;
        end
    end

    word_fifo #(
        .WIDTH (LOG_W),
        .DEPTH (LOG_DEPTH)
    ) u_log (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_reg),
        .in_valid_i  (log_push_w),
        .in_ready_o  (log_in_ready),
        .in_data_i   ({sel_reg, video_word_i}),
        .out_valid_o (log_out_valid),
        .out_ready_i (pop_log_w),
        .out_data_o  (log_out_data),
        .level_o     (log_level)
    );
    assign log_ready_o = log_in_ready;

    // Checks
    property p_no_seq_no_load;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (fall_w && !sequence_start_in_i && !low_power_select_w) |=> $stable(stage1_reg);
    endproperty
    a_no_seq_no_load: assert property (p_no_seq_no_load) else $error("load without sequence start");

    property p_addr_load;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (load_hit_w) |=> (stage1_reg[$past(sel_reg)] == $past(video_word_i));
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("word not captured");

    property p_load_holds_out;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (!xfer_w && !low_power_select_w) |=> $stable(chan_words_o);
    endproperty
    a_load_holds_out: assert property (p_load_holds_out) else $error("output moved without transfer");

    property p_low_power_select_quiet;
        @(posedge clk_i) disable iff (!rst_n_reg)
        low_power_select_w |-> (!log_push_w && !xfer_w) ##1 standby_o;
    endproperty
    a_low_power_select_quiet: assert property (p_low_power_select_quiet) else $error("activity in standby");

    property p_low_power_select_clear;
        @(posedge clk_i) disable iff (!rst_n_reg)
        low_power_select_w |=> (stage1_reg == '0) && (chan_words_o == '0) && (chan_valid_o == '0) && (valid1_reg == '0);
    endproperty
    a_low_power_select_clear: assert property (p_low_power_select_clear) else $error("data kept through standby");

    property p_resume;
        @(posedge clk_i) disable iff (!rst_n_reg)
        ($fell(standby_o) ##[1:40] load_hit_w) |=> valid1_reg[$past(sel_reg)];
    endproperty
    a_resume: assert property (p_resume) else $error("no load after standby");

    property p_direct;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (load_hit_w && xfr_pend_reg && output_transfer_in_i)
            |=> (chan_words_o[$past(sel_reg)*WORD_W +: WORD_W] == $past(video_word_i));
    endproperty
    a_direct: assert property (p_direct) else $error("direct load not shown");

    property p_xfer;
        @(posedge clk_i) disable iff (!rst_n_reg)
        xfer_w |=> (chan_words_o == $past(stage1_next)) && !xfr_pend_reg;
    endproperty
    a_xfer: assert property (p_xfer) else $error("outputs not updated together");

    property p_all_from_stage1;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (xfer_w ##1 1'b1) |-> (chan_valid_o == valid1_reg);
    endproperty
    a_all_from_stage1: assert property (p_all_from_stage1) else $error("channels out of step");

    property p_bad_sel;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (fall_w && !sel_ok_w && !low_power_select_w) |=> $stable(stage1_reg) && $stable(valid1_reg);
    endproperty
    a_bad_sel: assert property (p_bad_sel) else $error("select 6 or 7 changed a latch");

    property p_sel_capture;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (rise_w && !low_power_select_w) |=> (sel_reg == $past(chan_sel_i));
    endproperty
    a_sel_capture: assert property (p_sel_capture) else $error("select not taken on panel rise");

    property p_no_pend_hold;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (fall_w && !xfr_pend_reg && !low_power_select_w) |=> $stable(chan_valid_o) && $stable(chan_words_o);
    endproperty
    a_no_pend_hold: assert property (p_no_pend_hold) else $error("outputs moved on fall without transfer");

    property p_wake;
        @(posedge clk_i) disable iff (!rst_n_reg)
        $fell(low_power_select_w) |=> !standby_o;
    endproperty
    a_wake: assert property (p_wake) else $error("standby flag stuck after wake");

    c_addr_load: cover property (@(posedge clk_i) disable iff (!rst_n_reg) load_hit_w && !xfr_pend_reg);
    c_xfer: cover property (@(posedge clk_i) disable iff (!rst_n_reg) xfer_w);
    c_low_power_select: cover property (@(posedge clk_i) disable iff (!rst_n_reg) $fell(low_power_select_w));
    c_log_full: cover property (@(posedge clk_i) disable iff (!rst_n_reg) drop_set_w);
    c_direct: cover property (@(posedge clk_i) disable iff (!rst_n_reg) load_hit_w && xfr_pend_reg && output_transfer_in_i);
endmodule // chan_loader

`default_nettype wire

// [dv/panel_ctrl_model.sv]
// Purpose: Panel timing controller model driving the loader's panel pins
// Assumes: Runs off the bench clock; one panel clock period per frame call
// Notes:   Select and word lines show inverted values once their frame is over
`timescale 1ns/1ns
`default_nettype none

module panel_ctrl_model (
    input  wire logic       clk_i,
    output logic            pclk_o,
    output logic [2:0]      sel_o,
    output logic [9:0]      word_o,
    output logic            seq_o,
    output logic            xfr_o
);
    initial begin
        pclk_o = 1'b0;
        sel_o  = 3'h0;
        word_o = 10'h0;
        seq_o  = 1'b0;
        xfr_o  = 1'b0;
    end

    // Panel clock stands still low between frames; h is the half period in clocks
    task automatic frame(input logic [2:0] s, input logic [9:0] w, input logic x, input logic q, input int h);
        @(posedge clk_i);
        pclk_o <= 1'b1;
        sel_o  <= s;
        xfr_o  <= x;
        seq_o  <= q;
        repeat (h) @(posedge clk_i);
        pclk_o <= 1'b0;
        word_o <= w;
        repeat (h) @(posedge clk_i);
        sel_o  <= ~s;
        word_o <= ~w;
    endtask
endmodule // panel_ctrl_model

`default_nettype wire

// [dv/testbench.sv]
// Purpose: Self-checking bench for the addressed channel loader
// Assumes: Panel pins come from the controller model
// Notes:   Random loads use a fixed seed
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import chan_loader_pkg::*;
    logic                      clk_i, reset_n_i, lp, wr, rd, low_power_select, lrdy, pclk, seq, output_transfer_in, log_en, in_low_power_select;
    logic [ADDR_W-1:0]         addr;
    logic [DATA_W-1:0]         wdata, rdata, rv;
    logic [NUM_CH*WORD_W-1:0]  words;
    logic [NUM_CH-1:0]         valid, v1, vo;
    logic [SEL_W-1:0]          sel;
    logic [WORD_W-1:0]         word;
    logic [WORD_W-1:0]         s1 [NUM_CH];
    logic [WORD_W-1:0]         o1 [NUM_CH];
    logic [LOG_W-1:0]          logq [$];
    int                        err_count, checks_done;

    panel_ctrl_model pm (.clk_i(clk_i), .pclk_o(pclk), .sel_o(sel), .word_o(word), .seq_o(seq), .xfr_o(output_transfer_in));
    chan_loader uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .panel_clk_i(pclk), .chan_sel_i(sel),
        .video_word_i(word), .sequence_start_in_i(seq), .output_transfer_in_i(output_transfer_in),
        .low_power_select_i(lp), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .chan_words_o(words), .chan_valid_o(valid), .standby_o(low_power_select), .log_ready_o(lrdy));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask

    task automatic rreg(input logic [ADDR_W-1:0] a);
        @(posedge clk_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1 rv = rdata;
    endtask

    function automatic void clr();
        for (int k = 0; k < NUM_CH; k++) begin
            s1[k] = 10'h0;
            o1[k] = 10'h0;
        end
        v1 = '0;
        vo = '0;
    endfunction

    // Expected first and second stage after one panel period
    function automatic void step(input logic [2:0] s, input logic [9:0] w, input logic x, input logic q);
        if (q && !in_low_power_select && s < NUM_CH) begin
            s1[s] = w;
            v1[s] = 1'b1;
            if (log_en) logq.push_back({s, w});
        end
        if (x && !in_low_power_select) begin
            o1 = s1;
            vo = v1;
        end
    endfunction

    task automatic ld(input logic [2:0] s, input logic [9:0] w, input logic x, input logic q, input int h);
        logic [NUM_CH*WORD_W-1:0] p;
        pm.frame(s, w, x, q, h);
        step(s, w, x, q);
        repeat (2) @(posedge clk_i);
        #1;
        for (int k = 0; k < NUM_CH; k++) begin
            p[k*WORD_W +: WORD_W] = o1[k];
        end
        chk(words, p);
        chk(valid, vo);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #100000;
        err_count++;
        finish_test();
    end

    initial begin
        {reset_n_i, lp, wr, rd, log_en, in_low_power_select} = 6'h0;
        addr = '0;
        wdata = '0;
        err_count = 0;
        checks_done = 0;
        clr();
        void'($urandom(32'h3FE8));
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk(words, 64'h0);
        chk({valid, low_power_select}, 64'h0);
        chk(lrdy, 64'h1);
        rreg(CTRL_OFS);
        chk(rv, CTRL_LOG_EN_RST);
        rreg(4'hC);
        chk(rv, 64'h0);
        for (int k = 0; k < NUM_CH; k++) ld(3'(5 - k), 10'($urandom), 1'b0, 1'b1, 1);
        ld(3'h7, 10'($urandom), 1'b1, 1'b1, 2);
        ld(3'h2, 10'($urandom), 1'b0, 1'b0, 1);
        ld(3'h6, 10'h3FF, 1'b1, 1'b1, 1);
        repeat (12) ld(3'($urandom_range(7, 0)), 10'($urandom), 1'($urandom_range(1, 0)), 1'b1,
                       $urandom_range(3, 1));
        for (int k = 0; k < NUM_CH; k++) ld(3'(k), 10'($urandom), 1'b1, 1'b1, 1);
        log_en = 1'b1;
        wreg(CTRL_OFS, 32'h1);
        for (int i = 0; i < 33; i++) ld(3'(i % 6), 10'($urandom), 1'b0, 1'b1, 1);
        chk(lrdy, 64'h0);
        rreg(STATUS_OFS);
        chk({rv[STAT_DROP_BIT], rv[5:0]}, 64'h60);
        log_en = 1'b0;
        wreg(CTRL_OFS, 32'h0);
        for (int i = 0; i < 32; i++) begin
            rreg(LOG_OFS);
            chk(rv, {15'h0, 1'b1, 3'h0, logq[i]});
        end
        rreg(LOG_OFS);
        chk(rv[LOG_VALID_BIT], 64'h0);
        wreg(STATUS_OFS, 32'h200);
        rreg(STATUS_OFS);
        chk({rv[STAT_DROP_BIT], lrdy}, 64'h1);
        @(posedge clk_i);
        lp <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk(low_power_select, 64'h1);
        chk(valid, 64'h0);
        chk(words, 64'h0);
        rreg(STATUS_OFS);
        chk(rv[STAT_LOW_POWER_SELECT_BIT], 64'h1);
        in_low_power_select = 1'b1;
        clr();
        ld(3'h1, 10'($urandom), 1'b1, 1'b1, 1);
        @(posedge clk_i);
        lp <= 1'b0;
        in_low_power_select = 1'b0;
        repeat (2) @(posedge clk_i);
        ld(3'h4, 10'($urandom), 1'b1, 1'b1, 1);
        finish_test();
    end
endmodule // testbench

`default_nettype wire
